// ==== hdl/ppo_top.sv ====
// Purpose: 16-bit programmable pulse pattern output, four 4-bit groups
// Assumes: Compare-match pulses come from logic on mclk, one cycle wide
// Notes:   Registers over Avalon-MM, one wait state on every access
//          Map: 00 trigger select, 04 output mode (7:4 polarity, 3:0 overlap)
//          08/0c next bits of groups 2 and 3, 10/14 next bits of groups 0 and 1
//          18 output bits, 1c next enable, 20 port direction (15:8 port1)
//          A pair with equal triggers shares the lower address of its two;
//          the upper one then reads all ones and drops writes
//          Only byte lane 0 enables a write; unmapped words read zero
//          Transfers run whether or not a pin is enabled, so software can
//          preload a pattern before turning the pins on
//
// How it works
// - Two-bit field picks timer channel 0..3
// - Polarity bit: 0 inverted, 1 direct
// - Inverted: output bit 1 drives pin low
// - Overlap bit: 0 match A, 1 A or B
// - Pin active only when direction and enable set
// - Before trigger, pins show held output bits
// - Normal mode: selected match copies next into output
// - Non-overlap: match A copies every next bit
// - Non-overlap: match B copies only zero bits
// - Split triggers: unused nibble reads ones, ignores writes
//
// Local design decisions: the register offsets and register access over Avalon-MM.
`include "ppo_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module ppo_top
  import ppo_pkg::*;
#(
  parameter int GROUPS = 4
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst,
  // Avalon-MM slave
  input  wire ppo_avl_req_t     avl_req,
  output logic [31:0]           avl_readdata,
  output logic                  avl_waitrequest,
  // Timer compare-match pulses, one bit per channel
  input  wire logic [3:0]       cm_a,
  input  wire logic [3:0]       cm_b,
  // Pulse output pins
  output logic [4*GROUPS-1:0]   pulse_out,
  output logic [4*GROUPS-1:0]   pulse_oe_n
);

  localparam int W = 4 * GROUPS;

  // Bus handshake
  ppo_bus_st_t     bus_st_reg, bus_st_next;
  logic [31:0]     rdata_reg, rdata_next;

  // Software registers and output bits
  logic [7:0]      trig_sel_reg, trig_sel_next;
  logic [7:0]      out_mode_reg, out_mode_next;
  logic [W-1:0]    next_bits_reg, next_bits_next;
  logic [W-1:0]    out_bits_reg, out_bits_next;
  logic [W-1:0]    next_en_reg, next_en_next;
  logic [W-1:0]    port_dir_reg, port_dir_next;

  // Timer capture and pin stage
  logic [3:0]      cm_a_reg, cm_a_next;
  logic [3:0]      cm_b_reg, cm_b_next;
  logic [W-1:0]    pins_reg, pins_next;
  logic [W-1:0]    oe_n_reg, oe_n_next;

  // Per-group results and decode
  logic [W-1:0]    xfer_bits;
  logic [W-1:0]    xfer_mask;
  logic            split_hi;
  logic            split_lo;
  logic            wr_take;
  logic            req;

  // Pairs sharing a byte address split when their triggers differ
  assign split_hi = trig_sel_reg[7:6] != trig_sel_reg[5:4];
  assign split_lo = trig_sel_reg[3:2] != trig_sel_reg[1:0];

  // Waitrequest drops in the cycle after a request is first seen, so
  // every access costs exactly one wait state; read data is registered
  // then and stands until the next access replaces it
  assign req             = avl_req.read | avl_req.write;
  assign avl_waitrequest = req & (bus_st_reg != PPO_BUS_ACK);
  assign avl_readdata    = rdata_reg;
  assign wr_take         = avl_req.write & (bus_st_reg == PPO_BUS_ACK) & avl_req.byteenable[0];
  assign pulse_out       = pins_reg;
  assign pulse_oe_n      = oe_n_reg;

  // Per-group trigger pick and transfer mask
  genvar g;
  generate
    for (g = 0; g < GROUPS; g++) begin : g_grp
      logic [1:0] sel;
      logic       ev_a;
      logic       ev_b;
      logic       nov;
      logic       pol;
      logic [3:0] nib_next;
      logic [3:0] nib_out;
      logic [3:0] mask;
      logic [3:0] lvl;
      logic [3:0] live;
      logic [3:0] pin_lvl;
      logic [3:0] oe_lvl;
      assign sel      = trig_sel_reg[2*g+1:2*g];
      assign ev_a     = cm_a_reg[sel];
      assign ev_b     = cm_b_reg[sel];
      assign nov      = out_mode_reg[g];
      assign pol      = out_mode_reg[`PPO_POL_POS+g];
      assign nib_next = next_bits_reg[4*g+3:4*g];
      assign nib_out  = out_bits_reg[4*g+3:4*g];
      assign live     = port_dir_reg[4*g+3:4*g] & next_en_reg[4*g+3:4*g];
      // Match A wins over a same-cycle match B: a full copy covers both
      always_comb begin
        if (ev_a) begin
          mask = 4'hf;
        end else if (nov && ev_b) begin
          mask = ~nib_next;
        end else begin
          mask = 4'h0;
        end
      end
      always_comb begin
        if (pol) begin
          lvl = nib_out;
        end else begin
          lvl = ~nib_out;
        end
      end
      // Disabled pins sit low with the enable off, never half driven
      assign pin_lvl = lvl & live;
      assign oe_lvl  = ~live;
      assign xfer_bits[4*g+3:4*g] = nib_next;
      assign xfer_mask[4*g+3:4*g] = mask;
      assign pins_next[4*g+3:4*g] = pin_lvl;
      assign oe_n_next[4*g+3:4*g] = oe_lvl;
    end
  endgenerate

  // Bus handshake and read mux
  always_comb begin
    bus_st_next = bus_st_reg;
    rdata_next  = rdata_reg;
    case (bus_st_reg)
      PPO_BUS_IDLE: begin
        if (req) begin
          bus_st_next = PPO_BUS_ACK;
          rdata_next  = 32'h0000_0000;
          case (avl_req.address)
            `PPO_OFS_TRIG_SEL: rdata_next[7:0] = trig_sel_reg;
            `PPO_OFS_OUT_MODE: rdata_next[7:0] = out_mode_reg;
            `PPO_OFS_NEXT_HI: begin
              if (split_hi) begin
                rdata_next[7:0] = {`PPO_NIB_FILL, next_bits_reg[11:8]};
              end else begin
                rdata_next[7:0] = next_bits_reg[15:8];
              end
            end
            `PPO_OFS_NEXT_HI_UP: begin
              if (split_hi) begin
                rdata_next[7:0] = {next_bits_reg[15:12], `PPO_NIB_FILL};
              end else begin
                rdata_next[7:0] = `PPO_BYTE_FILL;
              end
            end
            `PPO_OFS_NEXT_LO: begin
              if (split_lo) begin
                rdata_next[7:0] = {`PPO_NIB_FILL, next_bits_reg[3:0]};
              end else begin
                rdata_next[7:0] = next_bits_reg[7:0];
              end
            end
            `PPO_OFS_NEXT_LO_UP: begin
              if (split_lo) begin
                rdata_next[7:0] = {next_bits_reg[7:4], `PPO_NIB_FILL};
              end else begin
                rdata_next[7:0] = `PPO_BYTE_FILL;
              end
            end
            `PPO_OFS_OUT_BITS: rdata_next[W-1:0] = out_bits_reg;
            `PPO_OFS_NEXT_EN:  rdata_next[W-1:0] = next_en_reg;
            `PPO_OFS_PORT_DIR: rdata_next[W-1:0] = port_dir_reg;
            default:           rdata_next = 32'h0000_0000;
          endcase
        end
      end
      PPO_BUS_ACK: begin
        bus_st_next = PPO_BUS_IDLE;
      end
      default: begin
        bus_st_next = PPO_BUS_IDLE;
      end
    endcase
  end

  // Register writes and pattern transfer
  always_comb begin
    trig_sel_next  = trig_sel_reg;
    out_mode_next  = out_mode_reg;
    next_bits_next = next_bits_reg;
    next_en_next   = next_en_reg;
    port_dir_next  = port_dir_reg;
    out_bits_next  = out_bits_reg;
    // A write lands at the edge that closes the acknowledge cycle
    if (wr_take) begin
      case (avl_req.address)
        `PPO_OFS_TRIG_SEL: trig_sel_next = avl_req.writedata[7:0];
        `PPO_OFS_OUT_MODE: out_mode_next = avl_req.writedata[7:0];
        `PPO_OFS_NEXT_HI: begin
          if (split_hi) begin
            next_bits_next[11:8] = avl_req.writedata[3:0];
          end else begin
            next_bits_next[15:8] = avl_req.writedata[7:0];
          end
        end
        `PPO_OFS_NEXT_HI_UP: begin
          if (split_hi) begin
            next_bits_next[15:12] = avl_req.writedata[7:4];
          end
        end
        `PPO_OFS_NEXT_LO: begin
          if (split_lo) begin
            next_bits_next[3:0] = avl_req.writedata[3:0];
          end else begin
            next_bits_next[7:0] = avl_req.writedata[7:0];
          end
        end
        `PPO_OFS_NEXT_LO_UP: begin
          if (split_lo) begin
            next_bits_next[7:4] = avl_req.writedata[7:4];
          end
        end
        `PPO_OFS_OUT_BITS: out_bits_next = avl_req.writedata[W-1:0];
        `PPO_OFS_NEXT_EN:  next_en_next  = avl_req.writedata[W-1:0];
        `PPO_OFS_PORT_DIR: port_dir_next = avl_req.writedata[W-1:0];
        default: begin
        end
      endcase
    end
    // Transfer beats a same-cycle software write so no match is lost;
    // transfer takes next bits as they stood before this cycle's write
    out_bits_next = (out_bits_next & ~xfer_mask) | (xfer_bits & xfer_mask);
  end

  // Bus state
  always_ff @(posedge mclk) begin
    if (rst) begin
      bus_st_reg <= PPO_BUS_IDLE;
      rdata_reg  <= 32'h0000_0000;
    end else begin
      bus_st_reg <= bus_st_next;
      rdata_reg  <= rdata_next;
    end
  end

  // Software registers and output bits
  always_ff @(posedge mclk) begin
    if (rst) begin
      trig_sel_reg  <= `PPO_RST_TRIG_SEL;
      out_mode_reg  <= `PPO_RST_OUT_MODE;
      next_bits_reg <= `PPO_RST_PATTERN;
      out_bits_reg  <= `PPO_RST_PATTERN;
      next_en_reg   <= `PPO_RST_PATTERN;
      port_dir_reg  <= `PPO_RST_PATTERN;
    end else begin
      trig_sel_reg  <= trig_sel_next;
      out_mode_reg  <= out_mode_next;
      next_bits_reg <= next_bits_next;
      out_bits_reg  <= out_bits_next;
      next_en_reg   <= next_en_next;
      port_dir_reg  <= port_dir_next;
    end
  end

  // One register stage keeps the pulses off the select mux; this is
  // why every transfer lands one cycle after its match
  always_comb begin
    cm_a_next = cm_a;
    cm_b_next = cm_b;
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      cm_a_reg <= 4'h0;
      cm_b_reg <= 4'h0;
    end else begin
      cm_a_reg <= cm_a_next;
      cm_b_reg <= cm_b_next;
    end
  end

  // Pin stage
  always_ff @(posedge mclk) begin
    if (rst) begin
      pins_reg <= `PPO_RST_PATTERN;
      oe_n_reg <= ~`PPO_RST_PATTERN;
    end else begin
      pins_reg <= pins_next;
      oe_n_reg <= oe_n_next;
    end
  end

endmodule : ppo_top
`default_nettype wire

// ==== hdl/ppo_defines.svh ====
// Purpose: Offsets, field positions, reset values of the pulse pattern output block
// Assumes: 32-bit Avalon-MM word addressing in bytes
// Notes:   Included by the package and the top module
`ifndef PPO_DEFINES_SVH
`define PPO_DEFINES_SVH

`define PPO_ADDR_W          6
`define PPO_OFS_TRIG_SEL    6'h00
`define PPO_OFS_OUT_MODE    6'h04
`define PPO_OFS_NEXT_HI     6'h08
`define PPO_OFS_NEXT_HI_UP  6'h0c
`define PPO_OFS_NEXT_LO     6'h10
`define PPO_OFS_NEXT_LO_UP  6'h14
`define PPO_OFS_OUT_BITS    6'h18
`define PPO_OFS_NEXT_EN     6'h1c
`define PPO_OFS_PORT_DIR    6'h20

`define PPO_RST_TRIG_SEL    8'hff
`define PPO_RST_OUT_MODE    8'hf0
`define PPO_RST_PATTERN     16'h0000
`define PPO_POL_POS         4
`define PPO_NIB_FILL        4'hf
`define PPO_BYTE_FILL       8'hff

`endif

// ==== hdl/ppo_pkg.sv ====
// Purpose: Types shared by the pulse pattern output block
// Assumes: ppo_defines.svh supplies the constants
// Notes:   Bus request travels as one packed struct
`include "ppo_defines.svh"
package ppo_pkg;
  typedef struct packed {
    logic                   read;
    logic                   write;
    logic [`PPO_ADDR_W-1:0] address;
    logic [3:0]             byteenable;
    logic [31:0]            writedata;
  } ppo_avl_req_t;

  typedef enum logic [0:0] {PPO_BUS_IDLE, PPO_BUS_ACK} ppo_bus_st_t;
endpackage : ppo_pkg

// ==== tb/ppo_timer_model.sv ====
// Purpose: Compare-match source for the pulse pattern block
// Assumes: Shares mclk; bench raises request levels
// Notes:   Edge detect keeps every match one cycle wide
`timescale 1ns/10ps
`default_nettype none
module ppo_timer_model (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // Match requests
  input  wire logic [3:0] fire_a,
  input  wire logic [3:0] fire_b,
  // Match pulses
  output logic [3:0]      cm_a,
  output logic [3:0]      cm_b
);
  logic [7:0] last_reg;
  logic [7:0] pulse_reg;
  logic [7:0] pulse_next;
  always_comb begin
    pulse_next = {fire_a, fire_b} & ~last_reg;
  end
  always_ff @(posedge mclk) begin
    last_reg  <= rst ? 8'h00 : {fire_a, fire_b};
    pulse_reg <= rst ? 8'h00 : pulse_next;
  end
  assign {cm_a, cm_b} = pulse_reg;
endmodule : ppo_timer_model
`default_nettype wire

// ==== tb/ppo_top_properties.sv ====
// Purpose: Port properties of the pulse pattern block
// Assumes: One clock, synchronous reset
// Notes:   Bound below the module
`timescale 1ns/10ps
`default_nettype none
module ppo_top_properties
  import ppo_pkg::*;
#(parameter int GROUPS = 4) (
  // Clock and reset
  input wire logic                mclk,
  input wire logic                rst,
  // Register bus
  input wire ppo_avl_req_t        avl_req,
  input wire logic [31:0]         avl_readdata,
  input wire logic                avl_waitrequest,
  // Timer and pins
  input wire logic [3:0]          cm_a,
  input wire logic [3:0]          cm_b,
  input wire logic [4*GROUPS-1:0] pulse_out,
  input wire logic [4*GROUPS-1:0] pulse_oe_n
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wire req = avl_req.read | avl_req.write;
  sequence s_one_wait; avl_waitrequest ##1 !avl_waitrequest; endsequence
  sequence s_quiet; !(|{cm_a, cm_b, avl_req.write}) [*3]; endsequence
  a_one_wait: assert property ($rose(req) |-> s_one_wait) else $error("bad wait");
  a_idle_ready: assert property (!req |-> !avl_waitrequest) else $error("stray wait");
  a_rdata_hold: assert property (!req |=> $stable(avl_readdata)) else $error("rdata moved");
  a_off_pin_low: assert property ((pulse_out & pulse_oe_n) == '0) else $error("off pin");
  a_pin_quiet: assert property (s_quiet |=> $stable(pulse_out)) else $error("pin moved");
  a_oe_cause: assert property ($changed(pulse_oe_n) |-> $past(avl_req.write, 2))
    else $error("oe moved");
  a_oe_quiet: assert property (!avl_req.write [*2] |=> $stable(pulse_oe_n)) else $error("oe");
  a_rst_release: assert property ($fell(rst) |-> pulse_out == '0 && &pulse_oe_n)
    else $error("reset pins");
endmodule : ppo_top_properties
bind ppo_top ppo_top_properties #(.GROUPS(GROUPS)) u_ppo_top_properties (.mclk, .rst,
  .avl_req, .avl_readdata, .avl_waitrequest, .cm_a, .cm_b, .pulse_out, .pulse_oe_n);
`default_nettype wire

// ==== tb/programmable_pulse_pattern_output_bench.sv ====
// Purpose: Self-checking bench for the pulse pattern block
// Assumes: 25 MHz mclk, registers over Avalon-MM
// Notes:   Pins settle two edges after a register write
`include "ppo_defines.svh"
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module programmable_pulse_pattern_output_bench
  import ppo_pkg::*;
;
  logic         mclk = 1'b0;
  logic         rst = 1'b1;
  ppo_avl_req_t req = '0;
  logic [3:0]   fire_a = '0;
  logic [3:0]   fire_b = '0;
  logic [3:0]   cm_a, cm_b;
  logic [31:0]  rdata;
  logic         wreq;
  logic [15:0]  pout, poe_n;
  int           n_fail = 0;
  int           comparisons = 0;
  initial forever #20 mclk = ~mclk;
  ppo_timer_model u_ppo_timer_model (.mclk, .rst, .fire_a, .fire_b, .cm_a, .cm_b);
  ppo_top u_ppo_top (.mclk, .rst, .avl_req(req), .avl_readdata(rdata),
    .avl_waitrequest(wreq), .cm_a, .cm_b, .pulse_out(pout), .pulse_oe_n(poe_n));
  task automatic bus(input logic w, input logic [5:0] a, input logic [15:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    @(posedge mclk);
    req <= '{read: !w, write: w, address: a, byteenable: be,
             writedata: {16'h0000, d}};
    // Read right at the edge, before that edge's register updates land
    do @(posedge mclk); while (wreq !== 1'b0);
    q = rdata;
    req <= '0;
  endtask : bus
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 4'hf, q);
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 16'h0000, 4'hf, q);
    `CHK(q, e)
  endtask : rd
  task automatic pins(input logic [15:0] e);
    repeat (2) @(negedge mclk);
    `CHK(pout, e)
  endtask : pins
  // Old value must still stand one edge before the transfer lands
  task automatic trig(input logic [3:0] a, input logic [3:0] b, input logic [15:0] e);
    logic [15:0] old;
    repeat (2) @(negedge mclk);
    old = pout;
    @(posedge mclk) fire_a <= a;
    fire_b <= b;
    @(posedge mclk) fire_a <= '0;
    fire_b <= '0;
    repeat (2) @(posedge mclk);
    @(negedge mclk) `CHK(pout, old)
    @(negedge mclk) `CHK(pout, e)
  endtask : trig
  task automatic t_reset();
    rd(`PPO_OFS_TRIG_SEL, 32'h000000ff);
    rd(`PPO_OFS_OUT_MODE, 32'h000000f0);
    rd(6'h3c, 32'h00000000);
    `CHK(poe_n, 16'hffff)
  endtask : t_reset
  task automatic t_normal();
    logic [15:0] p;
    wr(`PPO_OFS_PORT_DIR, 16'hffff);
    wr(`PPO_OFS_NEXT_EN, 16'hffff);
    wr(`PPO_OFS_OUT_BITS, 16'h1234);
    pins(16'h1234);
    for (int c = 0; c < 4; c++) begin
      p = 16'h0f0f << c;
      wr(`PPO_OFS_TRIG_SEL, {8'h00, {4{c[1:0]}}});
      wr(`PPO_OFS_NEXT_HI, {8'h00, p[15:8]});
      wr(`PPO_OFS_NEXT_LO, {8'h00, p[7:0]});
      trig(4'h1 << ((c + 1) % 4), 4'h0, c ? p >> 1 : 16'h1234);
      trig(4'h0, 4'h1 << c, c ? p >> 1 : 16'h1234);
      trig(4'h1 << c, 4'h0, p);
    end
  endtask : t_normal
  task automatic t_polarity();
    wr(`PPO_OFS_OUT_MODE, 16'h00a0);
    pins(16'h7878 ^ 16'h0f0f);
    wr(`PPO_OFS_OUT_MODE, 16'h00f0);
    wr(`PPO_OFS_PORT_DIR, 16'hf0ff);
    wr(`PPO_OFS_NEXT_EN, 16'hff00);
    pins(16'h7000);
    `CHK(poe_n, 16'h0fff)
    wr(`PPO_OFS_PORT_DIR, 16'hffff);
    wr(`PPO_OFS_NEXT_EN, 16'hffff);
  endtask : t_polarity
  task automatic t_nonoverlap();
    wr(`PPO_OFS_OUT_MODE, 16'h00ff);
    wr(`PPO_OFS_TRIG_SEL, 16'h00aa);
    wr(`PPO_OFS_OUT_BITS, 16'hf0f0);
    wr(`PPO_OFS_NEXT_HI, 16'h003c);
    wr(`PPO_OFS_NEXT_LO, 16'h003c);
    trig(4'h0, 4'h4, 16'h3030);
    trig(4'h4, 4'h0, 16'h3c3c);
  endtask : t_nonoverlap
  task automatic t_split();
    logic [31:0] q;
    wr(`PPO_OFS_TRIG_SEL, 16'h0001);
    wr(`PPO_OFS_NEXT_LO_UP, 16'h0050);
    wr(`PPO_OFS_NEXT_LO, 16'h00a9);
    rd(`PPO_OFS_NEXT_LO_UP, 32'h0000005f);
    rd(`PPO_OFS_NEXT_LO, 32'h000000f9);
    rd(`PPO_OFS_NEXT_HI_UP, 32'h000000ff);
    // Lane 0 off: the write must be dropped
    bus(1'b1, `PPO_OFS_OUT_BITS, 16'h0000, 4'he, q);
    rd(`PPO_OFS_OUT_BITS, 32'h00003c3c);
    trig(4'h2, 4'h0, 16'h3c39);
    trig(4'h1, 4'h0, 16'h3c59);
  endtask : t_split
  task automatic results();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results
  initial begin
    #400000;
    n_fail++;
    results();
  end
  initial begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_normal();
    t_polarity();
    t_nonoverlap();
    t_split();
    results();
  end
endmodule : programmable_pulse_pattern_output_bench
`default_nettype wire
